/* core/ebpm_pkg.sv */
// Constants for the external bus control and port-mapping block.
// Assumes a single 250 MHz clock and an AXI4-Lite register master.
//
// Notes on behaviour
// - Byte access: even gives strobe 1, bit zero 0; odd the reverse.
// - Aligned word access not split in narrow mode drives strobe 0 and address bit zero 0.
// - Strobe 1 with bit zero 1 marks a swapped misaligned word.
// - Only internal RAM accesses may show strobe and bit zero both high.
// - Misaligned word: addressed byte on low half, next byte on high.
// - Byte and word accesses may follow on consecutive cycles.
// - Peripheral mode removes the first sixteen expansion registers.
// - Expanded modes move ports A, B, C and their directions off-chip.
// - Wide expanded mode moves port D and its direction off-chip.
// - Narrow expanded mode uses an eight-bit external data bus.
// - Special narrow with port D emulation moves port D off-chip.
// - Expanded mode with port E emulation moves port E off-chip.
// - Port A drives address 15 to 8 when expanded or peripheral, else GPIO.
// - Port B drives address 7 to 0 when expanded or peripheral, else GPIO.
// - Direction bit 0 makes a pin an input, 1 an output.
// - Port A and B data registers read and write in single-chip modes only, reset zero.
// - Narrow mode splits external words into two successive byte cycles.
package ebpm_pkg;

   // ************************************************************
   // Register indices; the AXI byte address is four times these.
   // ************************************************************
   localparam logic [5:0] IDX_PORT_A_PINS = 6'h00;
   localparam logic [5:0] IDX_PORT_B_PINS = 6'h01;
   localparam logic [5:0] IDX_PORT_A_DIRECTION = 6'h02;
   localparam logic [5:0] IDX_PORT_B_DIRECTION = 6'h03;
   localparam logic [5:0] IDX_CONTROL = 6'h10;
   localparam logic [5:0] IDX_STATUS = 6'h11;
   localparam int AXI_ADDR_W = 8;
   localparam logic [7:0] PORT_RESET = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_DECERR = 2'b11;

   // ************************************************************
   // Control fields and operating mode codes.
   // ************************************************************
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_EMD_BIT = 3;
   localparam int CTRL_EME_BIT = 4;
   localparam logic [4:0] CTRL_RESET = 5'h00;
   localparam logic [2:0] MODE_SPECIAL_SINGLE = 3'h0;
   localparam logic [2:0] MODE_SPECIAL_NARROW = 3'h1;
   localparam logic [2:0] MODE_SPECIAL_PERIPH = 3'h2;
   localparam logic [2:0] MODE_SPECIAL_WIDE = 3'h3;
   localparam logic [2:0] MODE_NORMAL_SINGLE = 3'h4;
   localparam logic [2:0] MODE_NORMAL_NARROW = 3'h5;
   localparam logic [2:0] MODE_NORMAL_WIDE = 3'h7;

   // ************************************************************
   // Bus addresses of the expansion port registers.
   // ************************************************************
   localparam logic [15:0] ADDR_PORT_C = 16'h0004;
   localparam logic [15:0] ADDR_PORT_D = 16'h0005;
   localparam logic [15:0] ADDR_DIR_C = 16'h0006;
   localparam logic [15:0] ADDR_DIR_D = 16'h0007;
   localparam logic [15:0] ADDR_PORT_E = 16'h0008;
   localparam logic [15:0] ADDR_DIR_E = 16'h0009;
   localparam logic [15:0] EXP_REG_COUNT = 16'h0010;
   localparam logic [15:0] REG_SPACE_TOP = 16'h0200;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_SECOND = 2'b10
   } ebpm_state_e;

endpackage : ebpm_pkg

/* core/ebpm_top.sv */
// External bus cycle generator, port A/B pins and register map control.
// Assumes an AXI4-Lite master for registers and a CPU-side access port.
`timescale 1ns/100ps
module ebpm_top (
   // Clock, reset and clock enable.
   input wire logic I_CLK,
   input wire logic I_RESETN,
   input wire logic I_CE,
   // AXI4-Lite write address and data.
   input wire logic I_AWVALID,
   output logic O_AWREADY,
   input wire logic [ebpm_pkg::AXI_ADDR_W-1:0] I_AWADDR,
   input wire logic I_WVALID,
   output logic O_WREADY,
   input wire logic [31:0] I_WDATA,
   input wire logic [3:0] I_WSTRB,
   // AXI4-Lite write response.
   output logic O_BVALID,
   input wire logic I_BREADY,
   output logic [1:0] O_BRESP,
   // AXI4-Lite read.
   input wire logic I_ARVALID,
   output logic O_ARREADY,
   input wire logic [ebpm_pkg::AXI_ADDR_W-1:0] I_ARADDR,
   output logic O_RVALID,
   input wire logic I_RREADY,
   output logic [31:0] O_RDATA,
   output logic [1:0] O_RRESP,
   // CPU-side access request.
   input wire logic I_ACC_VALID,
   output logic O_ACC_READY,
   input wire logic [15:0] I_ACC_ADDR,
   input wire logic I_ACC_WRITE,
   input wire logic I_ACC_WORD,
   input wire logic I_ACC_RAM,
   input wire logic [15:0] I_ACC_WDATA,
   // External bus cycle outputs.
   output logic O_BUS_VALID,
   output logic O_BUS_EXTERNAL,
   output logic O_LOW_BYTE_STROBE,
   output logic O_ADDRESS_BIT_ZERO,
   output logic O_BUS_RW,
   output logic [15:0] O_BUS_ADDR,
   output logic [15:0] O_BUS_DATA,
   // Port A and port B pins.
   input wire logic [7:0] I_PORT_A_BITS,
   output logic [7:0] O_PORT_A_BITS,
   output logic [7:0] O_PORT_A_BITS_OE_N,
   input wire logic [7:0] I_PORT_B_BITS,
   output logic [7:0] O_PORT_B_BITS,
   output logic [7:0] O_PORT_B_BITS_OE_N
);
   import ebpm_pkg::*;

   // ************************************************************
   // Storage.
   // ************************************************************
   logic [7:0] port_a_pins, port_b_pins, port_a_direction, port_b_direction;
   logic [4:0] control;
   ebpm_state_e state;
   logic [15:0] second_addr;
   logic second_write, second_ext, bus_ram, aw_held, w_held, w_en;
   logic [7:0] second_byte, w_byte;
   logic [5:0] aw_idx;

   // ************************************************************
   // Mode decode.
   // ************************************************************
   logic [2:0] mode;
   logic emulate_port_d_bit, emulate_port_e_bit, narrow, wide, expanded, periph, ab_mapped;

   // Expanded covers narrow and wide; code 6 behaves as single chip.
   assign mode = control[CTRL_MODE_LSB +: 3];
   assign emulate_port_d_bit = control[CTRL_EMD_BIT];
   assign emulate_port_e_bit = control[CTRL_EME_BIT];
   assign narrow = (mode == MODE_SPECIAL_NARROW) ||
                   (mode == MODE_NORMAL_NARROW);
   assign wide = (mode == MODE_SPECIAL_WIDE) || (mode == MODE_NORMAL_WIDE);
   assign expanded = narrow || wide;
   assign periph = (mode == MODE_SPECIAL_PERIPH);
   assign ab_mapped = !(expanded || periph);

   // Decide whether an access becomes an external bus cycle.
   function automatic logic is_external(input logic [15:0] addr,
                                        input logic ram);
      logic ext;
      ext = 1'b0;
      if (ram) begin
         ext = 1'b0;
      end else if (addr < EXP_REG_COUNT) begin
         if (periph) begin
            ext = 1'b1;
         end else if (expanded) begin
            // Ports A, B, C and their directions live off-chip.
            ext = (addr < ADDR_PORT_D) || (addr == ADDR_DIR_C);
            if ((addr == ADDR_PORT_D) || (addr == ADDR_DIR_D)) begin
               ext = wide || ((mode == MODE_SPECIAL_NARROW) && emulate_port_d_bit);
            end
            if ((addr == ADDR_PORT_E) || (addr == ADDR_DIR_E)) begin
               ext = emulate_port_e_bit;
            end
         end
      end else begin
         ext = (addr >= REG_SPACE_TOP) && (expanded || periph);
      end
      return ext;
   endfunction : is_external

   // ************************************************************
   // Access request decode.
   // ************************************************************
   logic acc_take, acc_ext, misaligned, need_split;

   // A new request is taken every free cycle, byte or word alike.
   assign O_ACC_READY = (state == ST_IDLE);
   assign acc_take = I_ACC_VALID && O_ACC_READY && I_CE;
   assign acc_ext = is_external(I_ACC_ADDR, I_ACC_RAM);
   assign misaligned = I_ACC_WORD && I_ACC_ADDR[0];
   // Only RAM finishes an odd word in one cycle; the rest go in two bytes.
   assign need_split = I_ACC_WORD &&
                       ((acc_ext && narrow) || (misaligned && !I_ACC_RAM));

   // ************************************************************
   // Sequencer for the second half of a split word.
   // ************************************************************
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         state <= ST_IDLE;
         second_addr <= 16'h0000;
         second_write <= 1'b0;
         second_ext <= 1'b0;
         second_byte <= 8'h00;
      end else if (I_CE) begin
         unique case (state)
            ST_IDLE: begin
               if (acc_take && need_split) begin
                  state <= ST_SECOND;
                  second_addr <= I_ACC_ADDR + 16'h0001;
                  second_write <= I_ACC_WRITE;
                  second_ext <= is_external(I_ACC_ADDR + 16'h0001, 1'b0);
                  second_byte <= I_ACC_WDATA[7:0];
               end
            end
            ST_SECOND: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ************************************************************
   // Bus cycle outputs, registered one edge after the request.
   // ************************************************************
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         O_BUS_VALID <= 1'b0;
         O_BUS_EXTERNAL <= 1'b0;
         O_LOW_BYTE_STROBE <= 1'b1;
         O_ADDRESS_BIT_ZERO <= 1'b0;
         O_BUS_RW <= 1'b1;
         O_BUS_ADDR <= 16'h0000;
         O_BUS_DATA <= 16'h0000;
         bus_ram <= 1'b0;
      end else if (I_CE) begin
         O_BUS_VALID <= 1'b0;
         if (state == ST_SECOND) begin
            // Second byte: strobe and bit zero follow its own address.
            O_BUS_VALID <= 1'b1;
            O_BUS_EXTERNAL <= second_ext;
            O_LOW_BYTE_STROBE <= !second_addr[0];
            O_ADDRESS_BIT_ZERO <= second_addr[0];
            O_BUS_RW <= !second_write;
            O_BUS_ADDR <= second_addr;
            O_BUS_DATA <= {second_byte, second_byte};
            bus_ram <= 1'b0;
         end else if (acc_take) begin
            O_BUS_VALID <= 1'b1;
            O_BUS_EXTERNAL <= acc_ext;
            O_BUS_RW <= !I_ACC_WRITE;
            O_BUS_ADDR <= I_ACC_ADDR;
            O_ADDRESS_BIT_ZERO <= I_ACC_ADDR[0];
            bus_ram <= I_ACC_RAM;
            if (!I_ACC_WORD || need_split) begin
               // Byte cycle; the byte is copied to both halves so it
               // sits on the upper pins in narrow mode as well.
               O_LOW_BYTE_STROBE <= !I_ACC_ADDR[0];
               O_BUS_DATA <= {I_ACC_WDATA[15:8], I_ACC_WDATA[15:8]};
            end else if (misaligned) begin
               O_LOW_BYTE_STROBE <= 1'b1;
               O_BUS_DATA <= {I_ACC_WDATA[7:0], I_ACC_WDATA[15:8]};
            end else begin
               O_LOW_BYTE_STROBE <= 1'b0;
               O_BUS_DATA <= I_ACC_WDATA;
            end
         end
      end
   end

   // ************************************************************
   // Port A and port B pins.
   // ************************************************************
   // Expanded pins carry the address; the latch is kept for later use.
   always_comb begin
      if (!ab_mapped) begin
         O_PORT_A_BITS = O_BUS_ADDR[15:8];
         O_PORT_B_BITS = O_BUS_ADDR[7:0];
         O_PORT_A_BITS_OE_N = 8'h00;
         O_PORT_B_BITS_OE_N = 8'h00;
      end else begin
         O_PORT_A_BITS = port_a_pins;
         O_PORT_B_BITS = port_b_pins;
         O_PORT_A_BITS_OE_N = ~port_a_direction;
         O_PORT_B_BITS_OE_N = ~port_b_direction;
      end
   end

   // ************************************************************
   // AXI4-Lite write channel.
   // ************************************************************
   logic wr_go, wr_mapped;

   assign O_AWREADY = !aw_held && !O_BVALID;
   assign O_WREADY = !w_held && !O_BVALID;
   assign wr_go = aw_held && w_held && !O_BVALID && I_CE;
   // Port registers drop out of the map in expanded and peripheral modes.
   assign wr_mapped = (aw_idx == IDX_CONTROL) ||
      (ab_mapped && (aw_idx <= IDX_PORT_B_DIRECTION));

   // Address and data are held independently, in whichever order.
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_idx <= 6'h00;
         w_byte <= 8'h00;
         w_en <= 1'b0;
      end else if (I_CE) begin
         if (I_AWVALID && O_AWREADY) begin
            aw_held <= 1'b1;
            aw_idx <= I_AWADDR[7:2];
         end else if (wr_go) begin
            aw_held <= 1'b0;
         end
         if (I_WVALID && O_WREADY) begin
            w_held <= 1'b1;
            w_byte <= I_WDATA[7:0];
            w_en <= I_WSTRB[0];
         end else if (wr_go) begin
            w_held <= 1'b0;
         end
      end
   end

   // Response is raised on the edge that performs the write.
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         O_BVALID <= 1'b0;
         O_BRESP <= RESP_OKAY;
      end else if (I_CE) begin
         if (wr_go) begin
            O_BVALID <= 1'b1;
            O_BRESP <= wr_mapped ? RESP_OKAY : RESP_DECERR;
         end else if (I_BREADY) begin
            O_BVALID <= 1'b0;
         end
      end
   end

   // Register updates; only the low byte lane is implemented.
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         port_a_pins <= PORT_RESET;
         port_b_pins <= PORT_RESET;
         port_a_direction <= PORT_RESET;
         port_b_direction <= PORT_RESET;
         control <= CTRL_RESET;
      end else if (wr_go && wr_mapped && w_en) begin
         unique case (aw_idx)
            IDX_PORT_A_PINS: port_a_pins <= w_byte;
            IDX_PORT_B_PINS: port_b_pins <= w_byte;
            IDX_PORT_A_DIRECTION: port_a_direction <= w_byte;
            IDX_PORT_B_DIRECTION: port_b_direction <= w_byte;
            default: control <= w_byte[4:0];
         endcase
      end
   end

   // ************************************************************
   // AXI4-Lite read channel.
   // ************************************************************
   logic [7:0] port_a_view, port_b_view, status;
   logic [5:0] rd_idx;
   logic rd_mapped;

   // Inputs show the pin, outputs the latch.
   assign port_a_view = (I_PORT_A_BITS & ~port_a_direction) |
                        (port_a_pins & port_a_direction);
   assign port_b_view = (I_PORT_B_BITS & ~port_b_direction) |
                        (port_b_pins & port_b_direction);
   assign status = {4'h0, !ab_mapped,
                    is_external(ADDR_PORT_D, 1'b0),
                    is_external(ADDR_PORT_E, 1'b0),
                    state == ST_SECOND};
   assign rd_idx = I_ARADDR[7:2];
   assign rd_mapped = (rd_idx == IDX_CONTROL) || (rd_idx == IDX_STATUS) ||
      (ab_mapped && (rd_idx <= IDX_PORT_B_DIRECTION));
   assign O_ARREADY = !O_RVALID;

   // Data is captured on the address edge; out-of-map reads give zero.
   always_ff @(posedge I_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         O_RVALID <= 1'b0;
         O_RDATA <= 32'h0000_0000;
         O_RRESP <= RESP_OKAY;
      end else if (I_CE) begin
         if (I_ARVALID && O_ARREADY) begin
            O_RVALID <= 1'b1;
            O_RRESP <= rd_mapped ? RESP_OKAY : RESP_DECERR;
            O_RDATA <= 32'h0000_0000;
            if (rd_mapped) begin
               unique case (rd_idx)
                  IDX_PORT_A_PINS: O_RDATA[7:0] <= port_a_view;
                  IDX_PORT_B_PINS: O_RDATA[7:0] <= port_b_view;
                  IDX_PORT_A_DIRECTION: O_RDATA[7:0] <= port_a_direction;
                  IDX_PORT_B_DIRECTION: O_RDATA[7:0] <= port_b_direction;
                  IDX_CONTROL: O_RDATA[4:0] <= control;
                  default: O_RDATA[7:0] <= status;
               endcase
            end
         end else if (I_RREADY) begin
            O_RVALID <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Checks.
   // ************************************************************
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RESETN);

   AST_BYTE_EVEN: assert property (
      (acc_take && !I_ACC_WORD && !I_ACC_ADDR[0])
      |=> (O_LOW_BYTE_STROBE && !O_ADDRESS_BIT_ZERO))
      else $error("Even byte access has wrong strobe or bit zero.");
   AST_BYTE_ODD: assert property (
      (acc_take && !I_ACC_WORD && I_ACC_ADDR[0])
      |=> (!O_LOW_BYTE_STROBE && O_ADDRESS_BIT_ZERO))
      else $error("Odd byte access has wrong strobe or bit zero.");
   AST_WORD_ALIGNED: assert property (
      (acc_take && I_ACC_WORD && !I_ACC_ADDR[0] && !need_split)
      |=> (!O_LOW_BYTE_STROBE && !O_ADDRESS_BIT_ZERO &&
           O_BUS_RW == !$past(I_ACC_WRITE)))
      else $error("Aligned word access signalled wrongly.");
   AST_WORD_SWAP: assert property (
      (acc_take && misaligned && I_ACC_RAM)
      |=> (O_LOW_BYTE_STROBE && O_ADDRESS_BIT_ZERO &&
           O_BUS_DATA[7:0] == $past(I_ACC_WDATA[15:8]) &&
           O_BUS_DATA[15:8] == $past(I_ACC_WDATA[7:0])))
      else $error("Misaligned word data not swapped.");
   AST_RAM_ONLY: assert property (
      (O_BUS_VALID && O_LOW_BYTE_STROBE && O_ADDRESS_BIT_ZERO) |-> bus_ram)
      else $error("Strobe and bit zero high outside internal RAM.");
   AST_SPLIT: assert property (
      (acc_take && I_ACC_WORD && !I_ACC_ADDR[0] && acc_ext && narrow)
      |=> (O_LOW_BYTE_STROBE && state == ST_SECOND)
      ##1 (!I_CE || (!O_LOW_BYTE_STROBE && O_ADDRESS_BIT_ZERO)))
      else $error("Narrow external word not split into two bytes.");
   AST_EXP_EXTERNAL: assert property (
      (acc_take && expanded && !I_ACC_RAM && I_ACC_ADDR < ADDR_PORT_D)
      |=> O_BUS_EXTERNAL)
      else $error("Port A/B/C access stayed on-chip in expanded mode.");
   AST_PERIPH_EXTERNAL: assert property (
      (acc_take && periph && !I_ACC_RAM && I_ACC_ADDR < EXP_REG_COUNT)
      |=> O_BUS_EXTERNAL)
      else $error("Expansion register stayed on-chip in peripheral mode.");
   AST_ADDR_PINS: assert property (
      (expanded || periph) |-> (O_PORT_A_BITS == O_BUS_ADDR[15:8] &&
                                O_PORT_B_BITS == O_BUS_ADDR[7:0] &&
                                O_PORT_A_BITS_OE_N == 8'h00))
      else $error("Address not driven on port pins.");
   AST_DIRECTION: assert property (
      ab_mapped |-> (O_PORT_B_BITS_OE_N == ~port_b_direction))
      else $error("Port B pin direction does not follow its register.");
   AST_READ_VIEW: assert property (
      (I_ARVALID && O_ARREADY && I_CE && ab_mapped &&
       rd_idx == IDX_PORT_A_PINS)
      |=> (O_RDATA[7:0] == $past(port_a_view) && O_RVALID))
      else $error("Port A read does not mix pins and latch.");

   COV_SPLIT: cover property (acc_take && need_split ##2 acc_take);
   COV_SWAP: cover property (O_BUS_VALID && O_LOW_BYTE_STROBE &&
                             O_ADDRESS_BIT_ZERO);
   COV_BACK_TO_BACK: cover property (acc_take && !I_ACC_WORD
                                     ##1 acc_take && I_ACC_WORD);
   COV_WRITE_READ: cover property (wr_go ##[1:4] (I_ARVALID && O_ARREADY));

endmodule : ebpm_top

/* test/ebpm_far.sv */
// Far-side model: port replacement unit and outside pin levels.
// Assumes the block's bus cycle outputs and its port A/B pin enables.
`timescale 1ns/100ps
module ebpm_far (
   // Clock and bus cycle.
   input wire logic i_clk,
   input wire logic i_bus_valid,
   input wire logic i_bus_ext,
   input wire logic i_bus_rw,
   input wire logic [15:0] i_bus_addr,
   input wire logic [15:0] i_bus_data,
   // Port pins.
   input wire logic [7:0] i_level,
   input wire logic [7:0] i_a_out,
   input wire logic [7:0] i_a_oe_n,
   input wire logic [7:0] i_b_out,
   input wire logic [7:0] i_b_oe_n,
   output logic [7:0] o_a_pin,
   output logic [7:0] o_b_pin
);
   logic [7:0] rebuilt [16];
   // Undriven bits show what outside logic puts on them, never the latch.
   assign o_a_pin = (i_a_out & ~i_a_oe_n) | (i_level & i_a_oe_n);
   assign o_b_pin = (i_b_out & ~i_b_oe_n) | (i_level & i_b_oe_n);
   // Port registers that left the map are kept here from external writes.
   always @(posedge i_clk) begin
      if (i_bus_valid && i_bus_ext && !i_bus_rw &&
          i_bus_addr < 16'h0010) begin
         rebuilt[i_bus_addr[3:0]] <= i_bus_data[7:0];
      end
   end
endmodule : ebpm_far

/* test/external_bus_port_mapping_test.sv */
// Self-checking bench for the bus control and port-mapping block.
// Assumes ebpm_pkg and a 250 MHz clock; registers reached over AXI4-Lite.
`timescale 1ns/100ps
module external_bus_port_mapping_test;
   import ebpm_pkg::*;
   logic clk = 0, rstn = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
   logic awr, wr, bv, arr, rv, accr, bval, bext, bls, ba0, brw;
   logic accv = 0, accw = 0, accwd = 0, accram = 0;
   logic [7:0] awa = 0, ara = 0, lvl = 0, pao, paoe, pbo, pboe, pai, pbi;
   logic [31:0] wd = 0, rd;
   logic [1:0] br, rr;
   logic [15:0] acca = 0, accd = 0, baddr, bdata;
   logic [4:0] p_e;
   int fails = 0, tests_run = 0, cyc = 0;
   // Free-running clock; the cycle ceiling cuts a hang short.
   always #2 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails = fails + 1;
         tally_and_finish();
      end
   end
   ebpm_top i_ebpm_top (.I_CLK(clk), .I_RESETN(rstn), .I_CE(1'b1),
      .I_AWVALID(awv), .O_AWREADY(awr), .I_AWADDR(awa), .I_WVALID(wv),
      .O_WREADY(wr), .I_WDATA(wd), .I_WSTRB(4'hF), .O_BVALID(bv),
      .I_BREADY(bre), .O_BRESP(br), .I_ARVALID(arv), .O_ARREADY(arr),
      .I_ARADDR(ara), .O_RVALID(rv), .I_RREADY(rre), .O_RDATA(rd),
      .O_RRESP(rr), .I_ACC_VALID(accv), .O_ACC_READY(accr),
      .I_ACC_ADDR(acca), .I_ACC_WRITE(accw), .I_ACC_WORD(accwd),
      .I_ACC_RAM(accram), .I_ACC_WDATA(accd), .O_BUS_VALID(bval),
      .O_BUS_EXTERNAL(bext), .O_LOW_BYTE_STROBE(bls),
      .O_ADDRESS_BIT_ZERO(ba0), .O_BUS_RW(brw), .O_BUS_ADDR(baddr),
      .O_BUS_DATA(bdata), .I_PORT_A_BITS(pai), .O_PORT_A_BITS(pao),
      .O_PORT_A_BITS_OE_N(paoe), .I_PORT_B_BITS(pbi), .O_PORT_B_BITS(pbo),
      .O_PORT_B_BITS_OE_N(pboe));
   ebpm_far i_ebpm_far (.i_clk(clk), .i_bus_valid(bval), .i_bus_ext(bext),
      .i_bus_rw(brw), .i_bus_addr(baddr), .i_bus_data(bdata), .i_level(lvl),
      .i_a_out(pao), .i_a_oe_n(paoe), .i_b_out(pbo), .i_b_oe_n(pboe),
      .o_a_pin(pai), .o_b_pin(pbi));
   // ***************************************************************
   // Shared tasks; each but chk is entered just after a rising edge.
   // ***************************************************************
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   function automatic logic [4:0] ev(input logic s, a, w, x);
      return {1'b1, s, a, ~w, x};
   endfunction : ev
   task automatic axw(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] resp);
      logic ta, tw, da, dw;
      da = 0;
      dw = 0;
      awa <= a;
      wd <= d;
      awv <= 1;
      wv <= 1;
      while (!(da && dw)) begin
         @(negedge clk);
         ta = awr && !da;
         tw = wr && !dw;
         @(posedge clk);
         if (ta) begin awv <= 0; da = 1; end
         if (tw) begin wv <= 0; dw = 1; end
      end
      bre <= 1;
      do begin @(negedge clk); ta = bv; resp = br; @(posedge clk); end
      while (!ta);
      bre <= 0;
   endtask : axw
   task automatic rdchk(input logic [7:0] a, e, input logic [1:0] er);
      logic t;
      ara <= a;
      arv <= 1;
      do begin @(negedge clk); t = arr; @(posedge clk); end while (!t);
      arv <= 0;
      rre <= 1;
      do begin @(negedge clk); t = rv; @(posedge clk); end while (!t);
      rre <= 0;
      chk("rdata", rd, {24'h0, e});
      chk("rresp", {30'h0, rr}, {30'h0, er});
   endtask : rdchk
   // The cycle taken last is judged at the next falling edge.
   task automatic acc(input logic [15:0] a, input logic w, wo, ram,
                      input logic [15:0] d, input logic [4:0] e);
      logic t, first;
      first = 1;
      {acca, accw, accwd, accram, accd, accv} <= {a, w, wo, ram, d, 1'b1};
      do begin
         @(negedge clk);
         if (first && p_e[4]) chk("bus", {27'h0, bval, bls, ba0, brw, bext},
                                   {27'h0, p_e});
         first = 0;
         t = accr;
         @(posedge clk);
      end while (!t);
      p_e = e;
   endtask : acc
   task automatic flush();
      accv <= 0;
      @(negedge clk);
      chk("bus", {27'h0, bval, bls, ba0, brw, bext}, {27'h0, p_e});
      p_e = 0;
      @(posedge clk);
   endtask : flush
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tally_and_finish
   // Port registers, directions and the pin merge in single-chip mode.
   task automatic t_regs();
      logic [1:0] r;
      for (int i = 0; i < 4; i++) rdchk(8'(i * 4), 8'h00, RESP_OKAY);
      rdchk(8'h80, 8'h00, RESP_DECERR);
      chk("oe_a", {24'h0, paoe}, 32'hFF);
      lvl <= 8'h5A;
      axw({IDX_PORT_A_DIRECTION, 2'b00}, 32'h0F, r);
      axw({IDX_PORT_A_PINS, 2'b00}, 32'hA5, r);
      axw({IDX_PORT_B_DIRECTION, 2'b00}, 32'hF0, r);
      axw({IDX_PORT_B_PINS, 2'b00}, 32'h3C, r);
      chk("oe_a", {24'h0, paoe}, 32'hF0);
      chk("pin_b", {24'h0, pbo & ~pboe}, 32'h30);
      rdchk({IDX_PORT_A_DIRECTION, 2'b00}, 8'h0F, RESP_OKAY);
      rdchk({IDX_PORT_A_PINS, 2'b00}, 8'h55, RESP_OKAY);
      rdchk({IDX_PORT_B_PINS, 2'b00}, 8'h3A, RESP_OKAY);
   endtask : t_regs
   // Access types back to back, then an odd word that must split.
   task automatic t_types();
      acc(16'h0300, 0, 0, 0, 16'h0000, ev(1, 0, 0, 0));
      acc(16'h0301, 1, 0, 0, 16'h1100, ev(0, 1, 1, 0));
      acc(16'h0302, 0, 1, 0, 16'h0000, ev(0, 0, 0, 0));
      acc(16'h0304, 1, 1, 0, 16'h1234, ev(0, 0, 1, 0));
      acc(16'h0305, 0, 1, 1, 16'h0000, ev(1, 1, 0, 0));
      acc(16'h0305, 1, 1, 1, 16'hABCD, ev(1, 1, 1, 0));
      flush();
      chk("data", {16'h0, bdata}, 32'hCDAB);
      acc(16'h0307, 0, 1, 0, 16'h0000, ev(0, 1, 0, 0));
      flush();
      @(negedge clk);
      chk("bus", {11'h0, bval, bls, ba0, baddr}, {14'h0006, 16'h0308});
      @(posedge clk);
   endtask : t_types
   // Narrow expanded mode: refused port registers and a split word.
   task automatic t_narrow();
      logic [1:0] r;
      axw({IDX_CONTROL, 2'b00}, {29'h0, MODE_NORMAL_NARROW}, r);
      axw({IDX_PORT_A_PINS, 2'b00}, 32'h01, r);
      chk("bresp", {30'h0, r}, {30'h0, RESP_DECERR});
      acc(16'h1234, 1, 1, 0, 16'hBEEF, ev(1, 0, 1, 1));
      flush();
      @(negedge clk);
      chk("bus", {27'h0, bval, bls, ba0, brw, bext}, 32'h15);
      chk("addr_data", {baddr, bdata}, 32'h1235_EFEF);
      chk("pins", {pao, pbo, paoe, pboe}, 32'h1235_0000);
      @(posedge clk);
      rdchk({IDX_STATUS, 2'b00}, 8'h08, RESP_OKAY);
      acc(16'h0000, 1, 0, 0, 16'h7700, ev(1, 0, 1, 1));
      flush();
      @(negedge clk);
      chk("rebuilt", {24'h0, i_ebpm_far.rebuilt[0]}, 32'h77);
      @(posedge clk);
   endtask : t_narrow
   // Which registers leave the map, for each mode but special single chip, and each emulation bit.
   task automatic t_map();
      logic [1:0] r;
      logic [4:0] e;
      logic [4:0] ct [10] = '{5, 3, 7, 1, 9, 5, 5'h15, 2, 2, 4};
      logic [15:0] ad [10] = '{5, 5, 7, 5, 5, 8, 8, 16'h0F, 16'h10, 0};
      logic xe [10] = '{0, 1, 1, 0, 1, 0, 1, 1, 0, 0};
      for (int i = 0; i < 10; i++) begin
         axw({IDX_CONTROL, 2'b00}, {27'h0, ct[i]}, r);
         e = ev(~ad[i][0], ad[i][0], 0, xe[i]);
         acc(ad[i], 0, 0, 0, 16'h0000, e);
         flush();
      end
      chk("oe_a", {24'h0, paoe}, 32'hF0);
   endtask : t_map
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1;
      p_e = 0;
      @(posedge clk);
      t_regs();
      t_types();
      t_narrow();
      t_map();
      tally_and_finish();
   end
endmodule : external_bus_port_mapping_test
